// File: verilog/pio_top.v
// programmable pin block: apb config, input edge writes, cyclic output compare
// Notes on behaviour
// - function 5: input, rising edge writes first value
// - falling edge writes second value, same parameter
// - function 130: output high when masked compare holds
// - state code 6 means operation enabled
// - command 2 powers on, 9 off plus clear
// - signed speed setpoint drives axis motion
// - edge select: 0 none, 1 rise, 2 fall, 3 both
// - operator: 0 eq, 1 ne, 2 lt, 3 gt
// - output parameter read cyclically, pin updated after
`timescale 1ns/10ps
`include "pio_defines.vh"
module pio_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  pin_in,
  pin_out,
  pin_oe_n,
  drive_fault,
  amp_on,
  speed_cmd
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output reg pslverr;
  input wire [3:0] pin_in;
  output reg [3:0] pin_out;
  output wire [3:0] pin_oe_n;
  input wire drive_fault;
  output wire amp_on;
  output wire [31:0] speed_cmd;

  // per pin configuration, all writable over apb at any time;
  // a pin's role follows its function word alone, the other words
  // are read for whichever role it has
  reg [7:0] func_ff [0:3];
  reg [15:0] index_ff [0:3];
  reg [15:0] subidx_ff [0:3];
  reg [31:0] mask_ff [0:3];
  reg [1:0] switch_ff [0:3];
  reg [31:0] value1_ff [0:3];
  reg [31:0] value2_ff [0:3];

  reg [3:0] pend_ff;
  reg [3:0] pend_fall_ff;
  reg [1:0] scan_ff;
  wire [3:0] level;
  wire [3:0] rise;
  wire [3:0] fall;
  wire [3:0] is_in;
  wire [3:0] ev_rise;
  wire [3:0] ev_fall;
  wire [3:0] ev_any;
  wire [3:0] state_code;
  wire [31:0] rda_data;
  wire [31:0] rdb_data;
  reg [1:0] grant;
  reg [3:0] grant_hot;
  wire wr_en;
  wire [31:0] wr_data;
  wire [31:0] masked;
  reg cmp_hit;
  wire [1:0] sel_pin;
  wire [2:0] sel_fld;
  wire pin_space;
  reg rd_ok;
  reg [31:0] rd_word;
  wire setup;
  wire apb_wr;
  wire [3:0] pin_hot;
  wire [3:0] func_wr;
  integer k;
  integer ko;
  integer kc;

  // pins cross into the clock domain here; nothing else reads pin_in
  // two flops deep, so a pin edge costs two cycles before it is seen
  pio_edge_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pin_in),
    .level(level),
    .rise(rise),
    .fall(fall)
  );

  // edge qualification per pin; an edge on a pin in any other role
  // is dropped here and never reaches the pending bits
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_ev
      assign is_in[i] = func_ff[i] == `PIO_FUNC_INPUT;
      assign ev_rise[i] = is_in[i] & rise[i] & switch_ff[i][`PIO_EDGE_RISE_BIT];
      assign ev_fall[i] = is_in[i] & fall[i] & switch_ff[i][`PIO_EDGE_FALL_BIT];
      assign ev_any[i] = ev_rise[i] | ev_fall[i];
      // pin is released unless it is a programmable output
      assign pin_oe_n[i] = func_ff[i] != `PIO_FUNC_OUTPUT;
    end
  endgenerate

  // lowest pending pin gets the single store write port;
  // fixed priority keeps the arbiter small, and a pin would need an
  // edge every cycle to starve the others, which switches cannot give
  always @* begin
    grant = 2'h0;
    grant_hot = 4'h0;
    if (pend_ff[0]) begin
      grant = 2'h0;
      grant_hot = 4'h1;
    end else if (pend_ff[1]) begin
      grant = 2'h1;
      grant_hot = 4'h2;
    end else if (pend_ff[2]) begin
      grant = 2'h2;
      grant_hot = 4'h4;
    end else if (pend_ff[3]) begin
      grant = 2'h3;
      grant_hot = 4'h8;
    end
  end

  // input path timing, counted in clock edges from the pin moving:
  //   two edges through the synchroniser, the edge pulse following with no edge of its own,
  //   one to raise the pending bit and one to write the store.
  // pins that fire together are served lowest first, one per cycle;
  //   a waiting pin loses nothing, as its write value is worked out
  //   only in the cycle in which it is granted.
  assign wr_en = |pend_ff;
  // read-modify-write: kept bits under the mask, preset value ored in
  assign wr_data = (rda_data & mask_ff[grant]) |
                   (pend_fall_ff[grant] ? value2_ff[grant] : value1_ff[grant]);

  // a second edge while still pending only overwrites the rise/fall
  // choice, so the later edge decides which preset value is written
  // a new edge in the serving cycle re-arms the pin; set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 4'h0;
      pend_fall_ff <= 4'h0;
    end else begin
      pend_ff <= (pend_ff & ~grant_hot) | ev_any;
      for (k = 0; k < 4; k = k + 1) begin
        if (ev_any[k]) begin
          pend_fall_ff[k] <= ev_fall[k];
        end
      end
    end
  end

  // port a serves the input writes, port b the output scan, so both
  // paths run every cycle without waiting on each other
  pio_param_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .wr_idx(index_ff[grant]),
    .wr_sub(subidx_ff[grant]),
    .wr_data(wr_data),
    .rda_idx(index_ff[grant]),
    .rda_sub(subidx_ff[grant]),
    .rda_data(rda_data),
    .rdb_idx(index_ff[scan_ff]),
    .rdb_sub(subidx_ff[scan_ff]),
    .rdb_data(rdb_data),
    .drive_fault(drive_fault),
    .amp_on(amp_on),
    .speed_cmd(speed_cmd),
    .state_code(state_code)
  );

  // compare on the masked value, unsigned as the value range is 0..2^32-1
  // the mask applies before the operator, so a zero mask compares zero
  assign masked = rdb_data & mask_ff[scan_ff];
  always @* begin
    case (switch_ff[scan_ff])
      `PIO_CMP_EQ: cmp_hit = masked == value1_ff[scan_ff];
      `PIO_CMP_NE: cmp_hit = masked != value1_ff[scan_ff];
      `PIO_CMP_LT: cmp_hit = masked < value1_ff[scan_ff];
      `PIO_CMP_GT: cmp_hit = masked > value1_ff[scan_ff];
      default: cmp_hit = 1'b0;
    endcase
  end

  // a function write that leaves output mode lands at this edge too
  assign pin_hot = 4'h1 << sel_pin;
  assign func_wr = {4{apb_wr & pin_space & (sel_fld == `PIO_FLD_FUNC)}} & pin_hot;

  // one pin per cycle, so each output refreshes every four cycles;
  // a pin that is not an output is held low at every edge, not only
  // in its scan slot, so it never reads high while its driver is off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_ff <= 2'h0;
      pin_out <= 4'h0;
    end else begin
      scan_ff <= scan_ff + 2'h1;
      for (ko = 0; ko < 4; ko = ko + 1) begin
        if (func_wr[ko] && pwdata[7:0] != `PIO_FUNC_OUTPUT) begin
          pin_out[ko] <= 1'b0;
        end else if (func_ff[ko] != `PIO_FUNC_OUTPUT) begin
          pin_out[ko] <= 1'b0;
        end else if (scan_ff == ko[1:0]) begin
          pin_out[ko] <= cmp_hit;
        end
      end
    end
  end

  // apb register map, one aligned word each:
  //   0x000 read only: amp on in bit 4, drive state code in bits 3:0
  //   0x004 read only: speed setpoint as applied to the axis
  //   0x008 read only: pin outputs in bits 7:4, synchronised levels in 3:0
  //   0x100 + 0x20 * pin: seven configuration words per pin
  //     +0x00 function, +0x04 index, +0x08 subindex, +0x0C mask,
  //     +0x10 edge or operator select, +0x14 first value, +0x18 second value
  // anything else, and any write to the read-only words, answers pslverr
  // apb decode: zero wait states, data captured in the setup cycle, so a
  // read shows state as it stood one cycle before the access edge
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign apb_wr = psel & penable & pwrite;
  assign pin_space = paddr[11:8] == `PIO_PIN_BASE_HI && !paddr[7] && paddr[4:2] <= `PIO_FLD_VALUE2 && paddr[1:0] == 2'h0;
  assign sel_pin = paddr[6:5];
  assign sel_fld = paddr[4:2];

  // read word and error flag for whatever address stands on the bus
  always @* begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    if (pin_space) begin
      case (sel_fld)
        `PIO_FLD_FUNC: rd_word = {24'h000000, func_ff[sel_pin]};
        `PIO_FLD_INDEX: rd_word = {16'h0000, index_ff[sel_pin]};
        `PIO_FLD_SUBINDEX: rd_word = {16'h0000, subidx_ff[sel_pin]};
        `PIO_FLD_MASK: rd_word = mask_ff[sel_pin];
        `PIO_FLD_SWITCH: rd_word = {30'h00000000, switch_ff[sel_pin]};
        `PIO_FLD_VALUE1: rd_word = value1_ff[sel_pin];
        default: rd_word = value2_ff[sel_pin];
      endcase
    end else if (paddr == `PIO_ADDR_STATE && !pwrite) begin
      rd_word = {27'h0000000, amp_on, state_code};
    end else if (paddr == `PIO_ADDR_SPEED && !pwrite) begin
      rd_word = speed_cmd;
    end else if (paddr == `PIO_ADDR_PINS && !pwrite) begin
      rd_word = {24'h000000, pin_out, level};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // answer registered at the setup edge and held until the next setup;
  // writes read back zero so stale data never sits on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_word;
      pslverr <= ~rd_ok;
    end
  end

  // configuration writes land at the access edge
  // narrow fields take the low bits of the word; upper bits are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (kc = 0; kc < 4; kc = kc + 1) begin
        func_ff[kc] <= `PIO_RST_FUNC;
        index_ff[kc] <= `PIO_RST_HALF;
        subidx_ff[kc] <= `PIO_RST_HALF;
        mask_ff[kc] <= `PIO_RST_WORD;
        switch_ff[kc] <= `PIO_RST_SWITCH;
        value1_ff[kc] <= `PIO_RST_WORD;
        value2_ff[kc] <= `PIO_RST_WORD;
      end
    end else if (apb_wr && pin_space) begin
      case (sel_fld)
        `PIO_FLD_FUNC: func_ff[sel_pin] <= pwdata[7:0];
        `PIO_FLD_INDEX: index_ff[sel_pin] <= pwdata[15:0];
        `PIO_FLD_SUBINDEX: subidx_ff[sel_pin] <= pwdata[15:0];
        `PIO_FLD_MASK: mask_ff[sel_pin] <= pwdata;
        `PIO_FLD_SWITCH: switch_ff[sel_pin] <= pwdata[1:0];
        `PIO_FLD_VALUE1: value1_ff[sel_pin] <= pwdata;
        default: value2_ff[sel_pin] <= pwdata;
      endcase
    end
  end
endmodule // pio_top

// File: verilog/pio_defines.vh
// constants for the programmable pin block
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH
// pin function codes
`define PIO_FUNC_INPUT 8'h05
`define PIO_FUNC_OUTPUT 8'h82
// edge selection bits of a programmable input
`define PIO_EDGE_RISE_BIT 0
`define PIO_EDGE_FALL_BIT 1
// comparison operators of a programmable output
`define PIO_CMP_EQ 2'h0
`define PIO_CMP_NE 2'h1
`define PIO_CMP_LT 2'h2
`define PIO_CMP_GT 2'h3
// parameter addresses in the drive store
`define PIO_IDX_DRIVE 16'h001C
`define PIO_SUB_COMMAND 16'h0001
`define PIO_SUB_STATE 16'h0002
`define PIO_IDX_SPEED 16'h0024
`define PIO_SUB_SPEED 16'h0001
// drive commands and state codes
`define PIO_CMD_ENABLE 32'h00000002
`define PIO_CMD_DISABLE 32'h00000009
`define PIO_STATE_OFF 4'h4
`define PIO_STATE_ENABLED 4'h6
`define PIO_STATE_FAULT 4'h7
// apb register map
`define PIO_ADDR_STATE 12'h000
`define PIO_ADDR_SPEED 12'h004
`define PIO_ADDR_PINS 12'h008
`define PIO_PIN_BASE_HI 4'h1
`define PIO_FLD_FUNC 3'h0
`define PIO_FLD_INDEX 3'h1
`define PIO_FLD_SUBINDEX 3'h2
`define PIO_FLD_MASK 3'h3
`define PIO_FLD_SWITCH 3'h4
`define PIO_FLD_VALUE1 3'h5
`define PIO_FLD_VALUE2 3'h6
// reset values
`define PIO_RST_FUNC 8'h00
`define PIO_RST_WORD 32'h00000000
`define PIO_RST_HALF 16'h0000
`define PIO_RST_SWITCH 2'h0
`endif

// File: verilog/pio_edge_sync.v
// pin synchroniser and edge detector, one slice per pin
`timescale 1ns/10ps
module pio_edge_sync (
  pclk,
  presetn,
  pin_in,
  level,
  rise,
  fall
);
  input wire pclk;
  input wire presetn;
  input wire [3:0] pin_in;
  output wire [3:0] level;
  output wire [3:0] rise;
  output wire [3:0] fall;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      reg meta_ff;
      reg sync_ff;
      reg prev_ff;
      // first stage is read only by the second stage
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end else begin
          meta_ff <= pin_in[i];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      // one pulse per edge from successive samples
      assign rise[i] = sync_ff & ~prev_ff;
      assign fall[i] = ~sync_ff & prev_ff;
      assign level[i] = sync_ff;
    end
  endgenerate
endmodule // pio_edge_sync

// File: verilog/pio_param_store.v
// drive parameter store: command, speed setpoint and status word
`timescale 1ns/10ps
`include "pio_defines.vh"
module pio_param_store (
  pclk,
  presetn,
  wr_en,
  wr_idx,
  wr_sub,
  wr_data,
  rda_idx,
  rda_sub,
  rda_data,
  rdb_idx,
  rdb_sub,
  rdb_data,
  drive_fault,
  amp_on,
  speed_cmd,
  state_code
);
  input wire pclk;
  input wire presetn;
  input wire wr_en;
  input wire [15:0] wr_idx;
  input wire [15:0] wr_sub;
  input wire [31:0] wr_data;
  input wire [15:0] rda_idx;
  input wire [15:0] rda_sub;
  output wire [31:0] rda_data;
  input wire [15:0] rdb_idx;
  input wire [15:0] rdb_sub;
  output wire [31:0] rdb_data;
  input wire drive_fault;
  output wire amp_on;
  output reg [31:0] speed_cmd;
  output wire [3:0] state_code;

  reg amp_ff;
  reg fault_ff;
  reg [31:0] cmd_ff;
  reg [31:0] vel_ff;
  wire wr_cmd;
  wire wr_vel;

  assign wr_cmd = wr_en && wr_idx == `PIO_IDX_DRIVE && wr_sub == `PIO_SUB_COMMAND;
  assign wr_vel = wr_en && wr_idx == `PIO_IDX_SPEED && wr_sub == `PIO_SUB_SPEED;
  // fault outranks enable, so state 6 really means enabled without fault
  assign state_code = fault_ff ? `PIO_STATE_FAULT : (amp_ff ? `PIO_STATE_ENABLED : `PIO_STATE_OFF);
  assign amp_on = amp_ff;

  function [31:0] rd_mux;
    input [15:0] idx;
    input [15:0] sub;
    input [31:0] cmd;
    input [31:0] vel;
    input [3:0] st;
    begin
      rd_mux = 32'h00000000;
      if (idx == `PIO_IDX_DRIVE && sub == `PIO_SUB_COMMAND) begin
        rd_mux = cmd;
      end else if (idx == `PIO_IDX_DRIVE && sub == `PIO_SUB_STATE) begin
        rd_mux = {28'h0000000, st};
      end else if (idx == `PIO_IDX_SPEED && sub == `PIO_SUB_SPEED) begin
        rd_mux = vel;
      end
    end
  endfunction

  // stored values go in as arguments so the read ports follow every update
  assign rda_data = rd_mux(rda_idx, rda_sub, cmd_ff, vel_ff, state_code);
  assign rdb_data = rd_mux(rdb_idx, rdb_sub, cmd_ff, vel_ff, state_code);

  // command decode; a fault arriving with the clear command still wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_ff <= 1'b0;
      fault_ff <= 1'b0;
      cmd_ff <= `PIO_RST_WORD;
      vel_ff <= `PIO_RST_WORD;
      speed_cmd <= `PIO_RST_WORD;
    end else begin
      if (wr_cmd) begin
        cmd_ff <= wr_data;
      end
      if (wr_vel) begin
        vel_ff <= wr_data;
      end
      if (drive_fault) begin
        fault_ff <= 1'b1;
        amp_ff <= 1'b0;
      end else if (wr_cmd && wr_data == `PIO_CMD_ENABLE && !fault_ff) begin
        amp_ff <= 1'b1;
      end else if (wr_cmd && wr_data == `PIO_CMD_DISABLE) begin
        amp_ff <= 1'b0;
        fault_ff <= 1'b0;
      end
      // signed setpoint passed to the axis only while powered
      speed_cmd <= amp_ff ? vel_ff : 32'h00000000;
    end
  end
endmodule // pio_param_store

// File: dv/pio_top_props.sv
// port checker for the programmable pin block
`timescale 1ns/10ps
module pio_top_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [3:0] pin_in,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n,
  input wire drive_fault,
  input wire amp_on,
  input wire [31:0] speed_cmd
);
  reg [3:0] pin_q_ff;
  reg [3:0] quiet_ff;
  // cycles since a pin moved; saturates so long idle spans stay cheap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q_ff <= 4'h0;
      quiet_ff <= 4'hF;
    end else begin
      pin_q_ff <= pin_in;
      quiet_ff <= (pin_in != pin_q_ff) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd_state;
    psel && !penable && !pwrite && paddr == 12'h000;
  endsequence
  sequence s_ro_wr;
    psel && !penable && pwrite && paddr <= 12'h008;
  endsequence
  oe_out_a: assert property ((pin_out & pin_oe_n) == 4'h0) else $error("pin high outside output mode");
  oe_stable_a: assert property (!(psel && penable && pwrite) |=> $stable(pin_oe_n))
    else $error("pin mode moved without a write");
  ro_write_err_a: assert property (s_ro_wr |=> pslverr) else $error("read-only write not refused");
  state_read_a: assert property (s_rd_state |=> prdata[31:5] == 27'h0 && prdata[4] == $past(amp_on)
    && (prdata[4] ? prdata[3:0] == 4'h6 : prdata[3:0] != 4'h6)) else $error("bad state word");
  fault_off_a: assert property (drive_fault |-> ##[1:2] !amp_on) else $error("fault left amp on");
  amp_cause_a: assert property ($rose(amp_on) |-> quiet_ff <= 4'h8) else $error("amp on without edge");
  speed_cause_a: assert property ($changed(speed_cmd) && amp_on && $past(amp_on) |-> quiet_ff <= 4'h8)
    else $error("speed moved without edge");
  amp_off_speed_a: assert property (!amp_on ##1 !amp_on |-> speed_cmd == 32'h0)
    else $error("speed while amp off");
endmodule // pio_top_props

// File: dv/pio_switch_model.sv
// switch bank and pin wiring at the far side of the pins
`timescale 1ns/10ps
module pio_switch_model (
  input wire pclk,
  input wire [3:0] lvl_req,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe_n,
  output wire [3:0] pin_in
);
  reg [3:0] sw_ff = 4'h0;
  // contacts settle on a clock edge, in step with the block's own sampling
  always @(posedge pclk) sw_ff <= lvl_req;
  // the block's driver wins where enabled, the switch level elsewhere
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & sw_ff);
endmodule // pio_switch_model

// File: dv/pio_top_tb.sv
// self-checking bench for the programmable pin block
`timescale 1ns/10ps
module pio_top_tb;
  reg pclk, presetn, psel, penable, pwrite, drive_fault, e, po;
  reg [11:0] paddr;
  reg [31:0] pwdata, seed, cur, v1, c, r;
  reg [3:0] lvl_req;
  wire [31:0] prdata, speed_cmd;
  wire pready, pslverr, amp_on;
  wire [3:0] pin_in, pin_out, pin_oe_n;
  integer fails, checked, k;
  pio_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive_fault(drive_fault), .amp_on(amp_on), .speed_cmd(speed_cmd));
  pio_switch_model u_sw (.pclk(pclk), .lvl_req(lvl_req), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  task results;
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task ck(input [31:0] g, input [31:0] x);
    checked = checked + 1;
    if (g !== x) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask
  // one transfer, request held until pready is seen at a rising edge
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rd(input [11:0] a, input [31:0] x);
    apb(a, 1'h0, 32'h0);
    ck(r, x);
    ck({31'h0, e}, 32'h0);
  endtask
  // pin n setup: function, index, subindex, mask, switch, value1, value2
  task cfg(input [1:0] n, input [7:0] f, input [15:0] ix, input [31:0] m, input [1:0] s, input [31:0] a, b);
    apb({4'h1, 1'h0, n, 5'h00}, 1'h1, {24'h0, f});
    apb({4'h1, 1'h0, n, 5'h04}, 1'h1, {16'h0, ix});
    apb({4'h1, 1'h0, n, 5'h08}, 1'h1, {31'h0, ix == 16'h001C && f == 8'h82} + 32'h1);
    apb({4'h1, 1'h0, n, 5'h0C}, 1'h1, m);
    apb({4'h1, 1'h0, n, 5'h10}, 1'h1, {30'h0, s});
    apb({4'h1, 1'h0, n, 5'h14}, 1'h1, a);
    apb({4'h1, 1'h0, n, 5'h18}, 1'h1, b);
  endtask
  // a switch move, then time for sync, write and pin refresh to land
  task pin(input [1:0] n, input v);
    lvl_req[n] <= v;
    repeat (10) @(posedge pclk);
  endtask
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function cmp(input [31:0] a, input [1:0] op, input [31:0] b);
    case (op)
      2'h0: cmp = a == b;
      2'h1: cmp = a != b;
      2'h2: cmp = a < b;
      default: cmp = a > b;
    endcase
  endfunction
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // the run needs under 3000 cycles
  initial begin
    repeat (8000) @(posedge pclk);
    fails = fails + 1;
    results;
  end
  initial begin
    {presetn, psel, penable, pwrite, drive_fault, paddr, pwdata, lvl_req} = 0;
    fails = 0;
    checked = 0;
    seed = 32'h16E1;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(12'h000, 32'h4);
    rd(12'h004, 32'h0);
    apb(12'h000, 1'h1, 32'h6);
    ck({31'h0, e}, 32'h1);
    apb(12'hFFC, 1'h0, 32'h0);
    ck({31'h0, e}, 32'h1);
    cfg(2'h0, 8'h05, 16'h001C, 32'h0, 2'h3, 32'h2, 32'h9);
    cfg(2'h1, 8'h05, 16'h0024, 32'h0, 2'h3, 32'h258, 32'h0);
    cfg(2'h2, 8'h05, 16'h0024, 32'h0, 2'h3, 32'hFFFFFDA8, 32'h0);
    cfg(2'h3, 8'h82, 16'h001C, 32'hF, 2'h0, 32'h6, 32'h0);
    ck({28'h0, pin_oe_n}, 32'h7);
    rd(12'h134, 32'h258);
    pin(2'h0, 1'h1);
    rd(12'h000, 32'h16);
    ck({31'h0, pin_out[3]}, 32'h1);
    pin(2'h1, 1'h1);
    ck(speed_cmd, 32'h258);
    pin(2'h1, 1'h0);
    ck(speed_cmd, 32'h0);
    pin(2'h2, 1'h1);
    ck(speed_cmd, 32'hFFFFFDA8);
    pin(2'h2, 1'h0);
    ck(speed_cmd, 32'h0);
    cur = 32'h0;
    for (k = 0; k < 4; k = k + 1) begin
      v1 = xs(seed);
      seed = xs(v1);
      cfg(2'h1, 8'h05, 16'h0024, 32'h0, k[1:0], v1, seed);
      pin(2'h1, 1'h1);
      cur = k[0] ? v1 : cur;
      ck(speed_cmd, cur);
      pin(2'h1, 1'h0);
      cur = k[1] ? seed : cur;
      ck(speed_cmd, cur);
    end
    for (k = 0; k < 8; k = k + 1) begin
      v1 = xs(seed);
      seed = xs(v1);
      c = k[0] ? seed : cur & v1;
      cfg(2'h3, 8'h82, 16'h0024, v1, k[2:1], c, 32'h0);
      repeat (8) @(posedge pclk);
      po = cmp(cur & v1, k[2:1], c);
      ck({31'h0, pin_out[3]}, {31'h0, po});
    end
    drive_fault <= 1'h1;
    @(posedge pclk);
    drive_fault <= 1'h0;
    repeat (3) @(posedge pclk);
    rd(12'h000, 32'h7);
    pin(2'h0, 1'h0);
    rd(12'h000, 32'h4);
    pin(2'h0, 1'h1);
    rd(12'h000, 32'h16);
    ck(speed_cmd, cur);
    rd(12'h008, {24'h0, po, 3'h0, po, 3'h1});
    results;
  end
endmodule // pio_top_tb
bind pio_top pio_top_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .drive_fault(drive_fault), .amp_on(amp_on), .speed_cmd(speed_cmd));
